// *** pmrsc_pkg.sv ***
`default_nettype none
// ====================================================================
// shared constants
package pmrsc_pkg;
   // motor count and widths
   localparam int          MOTORS       = 4;
   localparam int          RT_W         = 32;
   localparam int          ADDR_W       = 8;
   // clock and run time tick
   localparam longint      CLK_HZ       = 50_000_000;
   localparam longint      RT_TICK_MS   = 1000;
   localparam longint      RT_TICK_CYC  = CLK_HZ / 1000 * RT_TICK_MS;
   // register byte offsets
   localparam logic [7:0]  OFS_POLICY   = 8'h00;
   localparam logic [7:0]  OFS_SCHEME   = 8'h04;
   localparam logic [7:0]  OFS_MODE     = 8'h08;
   localparam logic [7:0]  OFS_ROT      = 8'h0c;
   localparam logic [7:0]  OFS_STATUS   = 8'h10;
   localparam logic [7:0]  OFS_RT_SEL   = 8'h14;
   localparam logic [7:0]  OFS_RT_VAL   = 8'h18;
   // field positions
   localparam int          POL_ORDER_LSB = 0;
   localparam int          POL_STOP_LSB  = 8;
   localparam int          SCH_PID_BIT   = 8;
   localparam int          ST_INV_LSB    = 8;
   localparam int          ST_CNT_LSB    = 16;
   localparam int          ST_ACT_BIT    = 24;
   // motor order policy values
   localparam logic [1:0]  ORDER_FIXED    = 2'h0;
   localparam logic [1:0]  ORDER_EQUAL    = 2'h1;
   localparam logic [1:0]  ORDER_FIXED_SW = 2'h2;
   localparam logic [1:0]  ORDER_EQUAL_SW = 2'h3;
   // line motor stop policy values
   localparam logic [1:0]  STOP_ALL      = 2'h0;
   localparam logic [1:0]  STOP_ON_ALARM = 2'h1;
   localparam logic [1:0]  STOP_KEEP     = 2'h2;
   // per motor mode values and scheme off value
   localparam logic [1:0]  MODE_OFF     = 2'h0;
   localparam logic [1:0]  MODE_ON      = 2'h1;
   localparam logic [1:0]  MODE_FORCE   = 2'h2;
   localparam logic [7:0]  SCHEME_OFF   = 8'h00;
   // reset values and bus answers
   localparam logic [15:0] MODE_RST     = 16'h5555;
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;
endpackage : pmrsc_pkg
`default_nettype wire

// *** pmrsc_pick.sv ***
`default_nettype none
// ====================================================================
// picks the masked motor with the smallest or largest key
module pmrsc_pick #(
   parameter int N  = pmrsc_pkg::MOTORS,
   parameter int KW = pmrsc_pkg::RT_W,
   parameter int IW = $clog2(N)
) (
   input  wire logic [N*KW-1:0] key,
   input  wire logic [N-1:0]    mask,
   input  wire logic            want_max,
   output logic      [IW-1:0]   idx,
   output logic                 found
);
   // strict compare so the lowest number wins a tie
   always_comb begin
      logic [KW-1:0] best;
      best  = '0;
      idx   = '0;
      found = 1'b0;
      for (int i = 0; i < N; i++) begin
         if (mask[i] && (!found ||
             (want_max ? key[i*KW +: KW] > best
                       : key[i*KW +: KW] < best))) begin
            best  = key[i*KW +: KW];
            idx   = IW'(i);
            found = 1'b1;
         end
      end
   end
endmodule : pmrsc_pick
`default_nettype wire

// *** pmrsc_ctrl.sv ***
// How it works
// - order policy 0 adds motors lowest number first.
// - order policy 0 drops motors highest number first.
// - order policy 1 adds the stopped motor with least run time.
// - order policy 1 drops the running motor with most run time.
// - policy 2 is fixed order; slow stop moves inverter to next motor.
// - policy 3 is equal time; slow stop moves inverter to least time.
// - stop policy decides line motors on run drop or alarm.
// - run drop: inverter outputs clear when inverter output ceases.
// - alarm clears all inverter outputs at once.
// - stop policy 0 clears all line outputs except forced ones on run drop and alarm.
// - policy 1 keeps line motors on run drop; policy 2 keeps them on run drop and alarm.
// - mode 0 or permit low switches that one motor off.
// - scheme 0, pid disable or coast stop clears all line motors.
// - unchanged count for the interval swaps a running and stopped motor.
// - mode 2 forces line output on; 0 disables; 1 enables.
//
// The address map and the AXI4-Lite slave port are this design's own decisions.
`default_nettype none
module pmrsc_ctrl #(
   parameter int     N           = pmrsc_pkg::MOTORS,
   parameter longint TICK_CYCLES = pmrsc_pkg::RT_TICK_CYC
) (
   input  wire logic                        aclk,
   input  wire logic                        aresetn,
   input  wire logic [pmrsc_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                        s_axi_awvalid,
   output logic                             s_axi_awready,
   input  wire logic [31:0]                 s_axi_wdata,
   input  wire logic [3:0]                  s_axi_wstrb,
   input  wire logic                        s_axi_wvalid,
   output logic                             s_axi_wready,
   output logic      [1:0]                  s_axi_bresp,
   output logic                             s_axi_bvalid,
   input  wire logic                        s_axi_bready,
   input  wire logic [pmrsc_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic                        s_axi_arvalid,
   output logic                             s_axi_arready,
   output logic      [31:0]                 s_axi_rdata,
   output logic      [1:0]                  s_axi_rresp,
   output logic                             s_axi_rvalid,
   input  wire logic                        s_axi_rready,
   input  wire logic                        run_cmd,
   input  wire logic                        alarm,
   input  wire logic                        inverter_active,
   input  wire logic                        add_req,
   input  wire logic                        drop_req,
   input  wire logic                        slow_stop_req,
   input  wire logic                        coast_stop_input,
   input  wire logic [N-1:0]                motor_permit_in,
   output logic      [N-1:0]                line_drive_out,
   output logic      [N-1:0]                inverter_drive_out,
   output logic                             rotation_event
);
   localparam int IW = $clog2(N);
   localparam int RW = pmrsc_pkg::RT_W;

   // ==================================================================
   // helpers
   function automatic logic [IW-1:0] oh_idx(input logic [N-1:0] v);
      oh_idx = '0;
      for (int i = 0; i < N; i++) begin
         if (v[i]) oh_idx = IW'(i);
      end
   endfunction : oh_idx

   function automatic logic [7:0] count_ones(input logic [N-1:0] v);
      count_ones = '0;
      for (int i = 0; i < N; i++) begin
         count_ones = count_ones + {7'h00, v[i]};
      end
   endfunction : count_ones

   // ==================================================================
   // registers and state
   logic [1:0]     order_pol;
   logic [1:0]     stop_pol;
   logic [7:0]     scheme;
   logic           pid_en;
   logic [2*N-1:0] mode;
   logic [31:0]    rot_interval;
   logic [IW-1:0]  rt_sel;
   logic [RW-1:0]  rt [N];
   logic [N-1:0]   perm_s1, perm_s2;
   logic           coast_s1, coast_s2;
   logic [31:0]    tick_cnt;
   logic           tick;
   logic [31:0]    rot_timer;
   logic [7:0]     prev_cnt;
   logic [N-1:0]   next_line, next_inv;
   logic           rot_fire, add_fire, drop_fire;
   logic [N-1:0]   forced, off_mask, add_mask, drop_mask;
   logic [N-1:0]   run_mask, inv_mask;
   logic [N*RW-1:0] key_rt, key_add, key_drop, key_inv;
   logic [IW-1:0]  add_idx, drop_idx, inv_idx, rmax_idx, rmin_idx;
   logic           add_ok, drop_ok, inv_ok, rmax_ok, rmin_ok;
   logic           casc_en, running, run_stop, rot_due, equal_pol;
   logic           wr_en, rd_en;

   // ==================================================================
   // pin synchronisers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         perm_s1  <= '0;
         perm_s2  <= '0;
         coast_s1 <= 1'b0;
         coast_s2 <= 1'b0;
      end else begin
         perm_s1  <= motor_permit_in;
         perm_s2  <= perm_s1;
         coast_s1 <= coast_stop_input;
         coast_s2 <= coast_s1;
      end
   end

   // ==================================================================
   // candidate masks and selection keys
   assign casc_en   = (scheme != pmrsc_pkg::SCHEME_OFF) && pid_en
                      && !coast_s2;
   assign running   = run_cmd || inverter_active || (|inverter_drive_out);
   assign run_stop  = !run_cmd && !inverter_active;
   assign equal_pol = order_pol[0];
   assign rot_due   = (rot_interval != '0) && (rot_timer >= rot_interval);

   always_comb begin
      for (int i = 0; i < N; i++) begin
         forced[i]   = mode[2*i +: 2] == pmrsc_pkg::MODE_FORCE;
         off_mask[i] = (mode[2*i +: 2] == pmrsc_pkg::MODE_OFF)
                       || !perm_s2[i];
         add_mask[i] = (mode[2*i +: 2] == pmrsc_pkg::MODE_ON) && perm_s2[i]
                       && !line_drive_out[i] && !inverter_drive_out[i];
         key_rt[i*RW +: RW]   = rt[i];
         key_add[i*RW +: RW]  = equal_pol ? rt[i] : '0;
         key_drop[i*RW +: RW] = equal_pol ? rt[i]
                                          : RW'(i);
         key_inv[i*RW +: RW]  = equal_pol ? rt[i] : RW'((i + N - 1
                                - int'(oh_idx(inverter_drive_out))) % N);
      end
      drop_mask = line_drive_out & ~forced;
      run_mask  = line_drive_out & ~forced;
      inv_mask  = add_mask;
   end

   pmrsc_pick #(.N(N), .KW(RW)) u_add (
      .key(key_add), .mask(add_mask), .want_max(1'b0),
      .idx(add_idx), .found(add_ok));
   pmrsc_pick #(.N(N), .KW(RW)) u_drop (
      .key(key_drop), .mask(drop_mask), .want_max(1'b1),
      .idx(drop_idx), .found(drop_ok));
   pmrsc_pick #(.N(N), .KW(RW)) u_inv (
      .key(key_inv), .mask(inv_mask), .want_max(1'b0),
      .idx(inv_idx), .found(inv_ok));
   pmrsc_pick #(.N(N), .KW(RW)) u_rmax (
      .key(key_rt), .mask(run_mask), .want_max(1'b1),
      .idx(rmax_idx), .found(rmax_ok));
   pmrsc_pick #(.N(N), .KW(RW)) u_rmin (
      .key(key_rt), .mask(add_mask), .want_max(1'b0),
      .idx(rmin_idx), .found(rmin_ok));

   // ==================================================================
   // cascade decision
   always_comb begin
      next_line = line_drive_out;
      next_inv  = inverter_drive_out;
      rot_fire  = 1'b0;
      add_fire  = 1'b0;
      drop_fire = 1'b0;
      if (!casc_en) begin
         next_line = '0;
         next_inv  = '0;
      end else if (alarm) begin
         next_inv = '0;
         if (stop_pol != pmrsc_pkg::STOP_KEEP) begin
            next_line = '0;
         end
      end else if (run_stop) begin
         next_inv = '0;
         if (stop_pol == pmrsc_pkg::STOP_ALL) begin
            next_line = '0;
         end
      end else if (run_cmd) begin
         if (inverter_drive_out == '0) begin
            if (add_ok) next_inv = N'(1) << add_idx;
         end else if (slow_stop_req && order_pol[1]) begin
            if (inv_ok) next_inv = N'(1) << inv_idx;
         end else if (add_req && add_ok) begin
            next_line[add_idx] = 1'b1;
            add_fire = 1'b1;
         end else if (drop_req && drop_ok) begin
            next_line[drop_idx] = 1'b0;
            drop_fire = 1'b1;
         end else if (rot_due && rmax_ok && rmin_ok
                      && rt[rmax_idx] > rt[rmin_idx]) begin
            next_line[rmax_idx] = 1'b0;
            next_line[rmin_idx] = 1'b1;
            rot_fire = 1'b1;
         end
      end
      // per motor disable and forced drive
      next_line = (next_line & ~off_mask)
                  | (forced & ~off_mask & {N{casc_en}});
      next_inv  = next_inv & ~off_mask;
   end

   // drive outputs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         line_drive_out     <= '0;
         inverter_drive_out <= '0;
         rotation_event     <= 1'b0;
      end else begin
         line_drive_out     <= next_line;
         inverter_drive_out <= next_inv;
         rotation_event     <= rot_fire;
      end
   end

   // ==================================================================
   // run time tick, counters and rotation timer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tick_cnt <= '0;
         tick     <= 1'b0;
      end else if (tick_cnt == 32'(TICK_CYCLES - 1)) begin
         tick_cnt <= '0;
         tick     <= 1'b1;
      end else begin
         tick_cnt <= tick_cnt + 32'h0000_0001;
         tick     <= 1'b0;
      end
   end

   for (genvar g = 0; g < N; g++) begin : g_rt
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            rt[g] <= '0;
         end else if (tick && (line_drive_out[g]
                               || inverter_drive_out[g])) begin
            rt[g] <= rt[g] + RW'(1);
         end
      end
   end

   // restarts whenever the running count moves
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prev_cnt  <= '0;
         rot_timer <= '0;
      end else begin
         prev_cnt <= count_ones(line_drive_out | inverter_drive_out);
         if (prev_cnt != count_ones(line_drive_out | inverter_drive_out)
             || !run_cmd || rot_fire || rot_interval == '0) begin
            rot_timer <= '0;
         end else if (tick && !rot_due) begin
            rot_timer <= rot_timer + 32'h0000_0001;
         end
      end
   end

   // ==================================================================
   // axi4-lite write channel
   assign wr_en = s_axi_awvalid && s_axi_wvalid && !s_axi_awready
                  && !s_axi_bvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= pmrsc_pkg::RESP_OKAY;
      end else begin
         s_axi_awready <= wr_en;
         s_axi_wready  <= wr_en;
         if (wr_en) begin
            s_axi_bvalid <= 1'b1;
            if (s_axi_awaddr == pmrsc_pkg::OFS_POLICY
                || s_axi_awaddr == pmrsc_pkg::OFS_SCHEME
                || s_axi_awaddr == pmrsc_pkg::OFS_MODE
                || s_axi_awaddr == pmrsc_pkg::OFS_ROT
                || s_axi_awaddr == pmrsc_pkg::OFS_RT_SEL) begin
               s_axi_bresp <= pmrsc_pkg::RESP_OKAY;
            end else begin
               s_axi_bresp <= pmrsc_pkg::RESP_SLVERR;
            end
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // register writes, each field gated by the strobe of its own byte lane
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         order_pol    <= pmrsc_pkg::ORDER_FIXED;
         stop_pol     <= pmrsc_pkg::STOP_ALL;
         scheme       <= pmrsc_pkg::SCHEME_OFF;
         pid_en       <= 1'b0;
         mode         <= (2*N)'(pmrsc_pkg::MODE_RST);
         rot_interval <= '0;
         rt_sel       <= '0;
      end else if (wr_en) begin
         if (s_axi_awaddr == pmrsc_pkg::OFS_POLICY) begin
            if (s_axi_wstrb[0])
               order_pol <= s_axi_wdata[pmrsc_pkg::POL_ORDER_LSB +: 2];
            if (s_axi_wstrb[1])
               stop_pol <= s_axi_wdata[pmrsc_pkg::POL_STOP_LSB +: 2];
         end else if (s_axi_awaddr == pmrsc_pkg::OFS_SCHEME) begin
            if (!running) begin
               if (s_axi_wstrb[0]) scheme <= s_axi_wdata[7:0];
               if (s_axi_wstrb[1])
                  pid_en <= s_axi_wdata[pmrsc_pkg::SCH_PID_BIT];
            end
         end else if (s_axi_awaddr == pmrsc_pkg::OFS_MODE) begin
            // two bits a motor, four motors to a byte lane
            for (int i = 0; i < N; i++) begin
               if (s_axi_wstrb[i/4])
                  mode[2*i +: 2] <= s_axi_wdata[2*i +: 2];
            end
         end else if (s_axi_awaddr == pmrsc_pkg::OFS_ROT) begin
            for (int b = 0; b < 4; b++) begin
               if (s_axi_wstrb[b])
                  rot_interval[8*b +: 8] <= s_axi_wdata[8*b +: 8];
            end
         end else if (s_axi_awaddr == pmrsc_pkg::OFS_RT_SEL) begin
            if (s_axi_wstrb[0]) rt_sel <= s_axi_wdata[IW-1:0];
         end
      end
   end

   // ==================================================================
   // axi4-lite read channel
   assign rd_en = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= pmrsc_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= rd_en;
         if (rd_en) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= pmrsc_pkg::RESP_OKAY;
            s_axi_rdata  <= '0;
            if (s_axi_araddr == pmrsc_pkg::OFS_POLICY) begin
               s_axi_rdata[pmrsc_pkg::POL_ORDER_LSB +: 2] <= order_pol;
               s_axi_rdata[pmrsc_pkg::POL_STOP_LSB +: 2]  <= stop_pol;
            end else if (s_axi_araddr == pmrsc_pkg::OFS_SCHEME) begin
               s_axi_rdata[7:0] <= scheme;
               s_axi_rdata[pmrsc_pkg::SCH_PID_BIT] <= pid_en;
            end else if (s_axi_araddr == pmrsc_pkg::OFS_MODE) begin
               s_axi_rdata[2*N-1:0] <= mode;
            end else if (s_axi_araddr == pmrsc_pkg::OFS_ROT) begin
               s_axi_rdata <= rot_interval;
            end else if (s_axi_araddr == pmrsc_pkg::OFS_STATUS) begin
               s_axi_rdata[N-1:0] <= line_drive_out;
               s_axi_rdata[pmrsc_pkg::ST_INV_LSB +: N] <= inverter_drive_out;
               s_axi_rdata[pmrsc_pkg::ST_CNT_LSB +: 8] <=
                  count_ones(line_drive_out | inverter_drive_out);
               s_axi_rdata[pmrsc_pkg::ST_ACT_BIT] <= casc_en;
            end else if (s_axi_araddr == pmrsc_pkg::OFS_RT_SEL) begin
               s_axi_rdata[IW-1:0] <= rt_sel;
            end else if (s_axi_araddr == pmrsc_pkg::OFS_RT_VAL) begin
               s_axi_rdata <= 32'(rt[rt_sel]);
            end else begin
               s_axi_rresp <= pmrsc_pkg::RESP_SLVERR;
            end
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ==================================================================
   // assertions
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_alarm_inv_off: assert property (
      alarm |=> inverter_drive_out == '0)
      else $error("inverter output stayed on after alarm");
   a_alarm_line_off: assert property (
      alarm && stop_pol != pmrsc_pkg::STOP_KEEP
      |=> (line_drive_out & ~$past(forced)) == '0)
      else $error("line output stayed on after alarm");
   a_keep_line_run: assert property (
      casc_en && !alarm && run_stop && stop_pol != pmrsc_pkg::STOP_ALL
      && off_mask == '0
      |=> (line_drive_out & $past(line_drive_out))
          == $past(line_drive_out))
      else $error("line motor dropped on run removal");
   a_runoff_inv: assert property (
      !run_cmd ##1 !inverter_active && !run_cmd
      |=> inverter_drive_out == '0)
      else $error("inverter output held after output ceased");
   a_global_off: assert property (
      !casc_en |=> line_drive_out == '0)
      else $error("line outputs on while pump control off");
   a_indiv_off: assert property (
      1'b1 |=> (line_drive_out & $past(off_mask)) == '0)
      else $error("disabled motor still driven");
   a_forced_on: assert property (
      casc_en |=> (line_drive_out & $past(forced & ~off_mask))
                  == $past(forced & ~off_mask))
      else $error("forced motor not driven");
   a_inv_single: assert property (
      $onehot0(inverter_drive_out))
      else $error("more than one inverter motor");
   a_add_lowest: assert property (
      add_fire && !equal_pol
      |=> line_drive_out[$past(add_idx)]
          && ($past(add_mask) & ((N'(1) << $past(add_idx)) - N'(1)))
             == '0)
      else $error("fixed add skipped a lower motor");
   a_drop_highest: assert property (
      drop_fire && !equal_pol |-> (drop_mask >> drop_idx) == N'(1))
      else $error("fixed drop skipped a higher motor");
   a_scheme_locked: assert property (
      wr_en && running && s_axi_awaddr == pmrsc_pkg::OFS_SCHEME
      |=> $stable(scheme) && $stable(pid_en))
      else $error("scheme changed while running");
   a_rot_swap: assert property (
      rot_fire |=> rotation_event
      && $countones(line_drive_out) == $countones($past(line_drive_out)))
      else $error("rotation changed running count");

   c_add: cover property (add_fire ##2 drop_fire);
   c_alarm: cover property (alarm && line_drive_out != '0);
   c_rotate: cover property (rot_fire);
   c_slow_stop: cover property (slow_stop_req && order_pol[1] && inv_ok);
endmodule : pmrsc_ctrl
`default_nettype wire

// *** pmrsc_partner.sv ***
`default_nettype none
// ==========
// inverter model: runs while a motor is selected, coasts after run drop
module pmrsc_partner #(
   parameter int DECEL = 4
) (
   input  wire logic       aclk,
   input  wire logic       run_cmd,
   input  wire logic       alarm,
   input  wire logic [3:0] inverter_drive_out,
   output logic            inverter_active,
   output logic      [3:0] motor_permit_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] cnt = 4'h0;
   // output cut at once on alarm, decays over DECEL cycles after run drop
   always_ff @(posedge aclk) begin
      if (alarm || inverter_drive_out == 4'h0) cnt <= 4'h0;
      else if (run_cmd) cnt <= DECEL[3:0];
      else if (cnt != 4'h0) cnt <= cnt - 4'h1;
   end
   // contactors all permitted
   assign inverter_active  = cnt != 4'h0;
   assign motor_permit_in  = 4'hf;
endmodule : pmrsc_partner
`default_nettype wire

// *** pump_motor_rotation_stop_control_tb.sv ***
`default_nettype none
// ==========
// bench top
module pump_motor_rotation_stop_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        aclk = 1'h0, aresetn = 1'h0, run_cmd = 1'h0, alarm = 1'h0;
   logic        add_req = 1'h0, drop_req = 1'h0, slow_stop_req = 1'h0;
   logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
   logic        s_axi_arvalid = 1'h0, s_axi_bready = 1'h0;
   logic        s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
   logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        inverter_active, rotation_event, coast_stop_input = 1'h0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rs;
   logic [3:0]  s_axi_wstrb = 4'hf, motor_permit_in;
   logic [3:0]  line_drive_out, inverter_drive_out;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [65:0] q[$];
   logic [65:0] e;
   int          fails = 0, checks_done = 0;
   always #10 aclk = ~aclk;
   pmrsc_ctrl #(.TICK_CYCLES(10)) uut (.aclk, .aresetn, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .run_cmd,
      .alarm, .inverter_active, .add_req, .drop_req, .slow_stop_req,
      .coast_stop_input, .motor_permit_in, .line_drive_out,
      .inverter_drive_out, .rotation_event);
   pmrsc_partner far (.aclk, .run_cmd, .alarm, .inverter_drive_out,
      .inverter_active, .motor_permit_in);
   // compares each bus answer with the oldest note
   always @(posedge aclk) begin
      if ((s_axi_bvalid && s_axi_bready)
          || (s_axi_rvalid && s_axi_rready)) begin
         e = q.pop_front();
         checks_done++;
         if ((s_axi_bvalid ? {s_axi_bresp, 32'h0}
              : {s_axi_rresp, s_axi_rdata & e[65:34]}) !== e[33:0]) begin
            fails++;
            $display("ERROR %0t: answer %h", $time, e[33:0]);
         end
      end
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] r);
      @(posedge aclk);
      q.push_back({32'h0, r, 32'h0});
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'h0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] x, m,
                     input logic [1:0] r);
      @(posedge aclk);
      q.push_back({m, r, x & m});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'h0;
   endtask : rd
   task automatic step(input logic ad);
      @(posedge aclk);
      add_req <= ad;
      drop_req <= !ad;
      @(posedge aclk);
      add_req <= 1'h0;
      drop_req <= 1'h0;
   endtask : step
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : tally_and_finish
   // watchdog
   initial begin
      repeat (3000) @(posedge aclk);
      fails++;
      tally_and_finish();
   end
   // main sequence
   initial begin
      rs = $urandom(32'hb0bf);
      repeat (8) @(posedge aclk);
      aresetn <= 1'h1;
      rd(pmrsc_pkg::OFS_POLICY, 32'h0, 32'h303, 2'h0);
      rd(pmrsc_pkg::OFS_MODE, 32'h55, 32'hff, 2'h0);
      rd(8'h40, 32'h0, 32'hffffffff, pmrsc_pkg::RESP_SLVERR);
      wr(pmrsc_pkg::OFS_STATUS, 32'h0, pmrsc_pkg::RESP_SLVERR);
      rs = $urandom & 32'h3;
      wr(pmrsc_pkg::OFS_RT_SEL, rs, 2'h0);
      rd(pmrsc_pkg::OFS_RT_SEL, rs, 32'h3, 2'h0);
      $display("test registers done");
      wr(pmrsc_pkg::OFS_SCHEME, 32'h101, 2'h0);
      run_cmd <= 1'h1;
      step(1'h1);
      step(1'h1);
      step(1'h0);
      rd(pmrsc_pkg::OFS_STATUS, 32'h102, 32'hf0f, 2'h0);
      wr(pmrsc_pkg::OFS_SCHEME, 32'h0, 2'h0);
      rd(pmrsc_pkg::OFS_SCHEME, 32'h101, 32'h1ff, 2'h0);
      $display("test fixed order done");
      alarm <= 1'h1;
      rd(pmrsc_pkg::OFS_STATUS, 32'h0, 32'hf0f, 2'h0);
      alarm <= 1'h0;
      step(1'h1);
      wr(pmrsc_pkg::OFS_POLICY, 32'h200, 2'h0);
      alarm <= 1'h1;
      rd(pmrsc_pkg::OFS_STATUS, 32'h2, 32'hf0f, 2'h0);
      alarm <= 1'h0;
      repeat (3) @(posedge aclk);
      run_cmd <= 1'h0;
      rd(pmrsc_pkg::OFS_STATUS, 32'h102, 32'hf0f, 2'h0);
      repeat (8) @(posedge aclk);
      rd(pmrsc_pkg::OFS_STATUS, 32'h2, 32'hf0f, 2'h0);
      $display("test stop policy done");
      wr(pmrsc_pkg::OFS_MODE, 32'h45, 2'h0);
      wr(pmrsc_pkg::OFS_ROT, 32'h3, 2'h0);
      run_cmd <= 1'h1;
      do @(posedge aclk); while (!rotation_event);
      rd(pmrsc_pkg::OFS_STATUS, 32'h20108, 32'hff0f0f,
         2'h0);
      wr(pmrsc_pkg::OFS_POLICY, 32'h202, 2'h0);
      slow_stop_req <= 1'h1;
      @(posedge aclk);
      slow_stop_req <= 1'h0;
      rd(pmrsc_pkg::OFS_STATUS, 32'h20208, 32'hff0f0f, 2'h0);
      coast_stop_input <= 1'h1;
      repeat (4) @(posedge aclk);
      rd(pmrsc_pkg::OFS_STATUS, 32'h0, 32'h1ff0f0f, 2'h0);
      $display("test rotation and coast done");
      tally_and_finish();
   end
endmodule : pump_motor_rotation_stop_control_tb
`default_nettype wire
